// File: verilog/hccr_defines.svh
// Register offsets, field positions, reset values and timing constants
// Summary of operation
// - In mode 3, input-select bit picks PWM (0) or analog (1) pin input.
// - PWM input: drive amplitude follows measured pin duty cycle.
// - Analog input: drive amplitude follows sampled pin amplitude.
// - Fixed-frequency bit: 0 auto-resonance tracking, 1 drive at selected frequency.
// - Fixed-frequency PWM mode: commutation frequency is PWM frequency divided by 128.
// - Calibration time field 0..3 gives 150/250/500/1000 ms minimum; resets to 2.
// - Read-only bit 2 shows whether nonvolatile memory was programmed.
// - Writing 1 to launch bit copies registers 0x16..0x1a into nonvolatile store.
// - Nonvolatile programming happens only once; later launches are ignored.
// - Supply monitor is 8-bit code, volts equal code times 5.6 over 255.
// - Supply reading updates only while a waveform is actively driven; a host write to 0x21 also loads the register at any time.
`ifndef HCCR_DEFINES_SVH
`define HCCR_DEFINES_SVH
`define HCCR_ADDR_CTRL3 8'h1d
`define HCCR_ADDR_CTRL4 8'h1e
`define HCCR_ADDR_VMON 8'h21
`define HCCR_ADDR_RPER 8'h22
`define HCCR_ADDR_OTP_FIRST 8'h16
`define HCCR_ADDR_OTP_LAST 8'h1a
`define HCCR_MODE_INPUT 3'h3
`define HCCR_C3_FIXED_FREQ 0
`define HCCR_C3_ANALOG_SEL 1
`define HCCR_C4_OTP_PROG 0
`define HCCR_C4_OTP_STAT 2
`define HCCR_C4_CAL_LO 4
`define HCCR_C4_CAL_HI 5
`define HCCR_C4_WMASK 8'h31
`define HCCR_CAL_RESET 2'h2
`define HCCR_CAL0_MS 150
`define HCCR_CAL1_MS 250
`define HCCR_CAL2_MS 500
`define HCCR_CAL3_MS 1000
`define HCCR_CLK_KHZ 125000
`define HCCR_COMM_DIV 128
`define HCCR_OTP_PROG_CYC 16
`define HCCR_CODE_FULL 8'hff
`endif

// File: verilog/hccr_pkg.sv
// Types for the haptic control configuration registers
package hccr_pkg;
  typedef enum logic [2:0] {
    HCCR_OTP_IDLE = 3'b001,
    HCCR_OTP_BUSY = 3'b010,
    HCCR_OTP_DONE = 3'b100
  } hccr_otp_e;
endpackage

// File: verilog/hccr_pwm_meter.sv
// Duty cycle meter and divide-by-128 commutation recovery
`timescale 1ns/1ps
`default_nettype none
`include "hccr_defines.svh"
module hccr_pwm_meter #(
  parameter int CW = 16
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic [7:0] duty_out,
  output logic comm_tick_out
);
  if (CW < 9) begin : g_cw_chk
    $error("hccr_pwm_meter: CW too small");
  end
  logic rise;
  logic prev_q;
  logic [CW-1:0] high_q, per_q;
  logic [6:0] div_q;
  assign rise = pin_in & ~prev_q;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) prev_q <= 1'b0;
    else prev_q <= pin_in;
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      high_q <= '0;
      per_q <= '0;
      duty_out <= 8'h00;
    end else if (rise) begin
      per_q <= CW'(1);
      high_q <= CW'(1);
      if (per_q != '0)
        duty_out <= 8'((high_q * 32'(`HCCR_CODE_FULL)) / per_q);
    end else begin
      if (~&per_q) per_q <= per_q + CW'(1);
      if (pin_in && ~&high_q) high_q <= high_q + CW'(1);
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= 7'h00;
      comm_tick_out <= 1'b0;
    end else begin
      comm_tick_out <= 1'b0;
      if (rise) begin
        div_q <= div_q + 7'h01;
        if (div_q == 7'(`HCCR_COMM_DIV - 1)) comm_tick_out <= 1'b1;
      end
    end
  end
endmodule // hccr_pwm_meter
`default_nettype wire

// File: verilog/hccr_regs.sv
// Haptic control configuration and monitor register bank
`timescale 1ns/1ps
`default_nettype none
`include "hccr_defines.svh"
module hccr_regs
  import hccr_pkg::*;
#(
  parameter int CAL0_CYC = `HCCR_CAL0_MS * `HCCR_CLK_KHZ,
  parameter int CAL1_CYC = `HCCR_CAL1_MS * `HCCR_CLK_KHZ,
  parameter int CAL2_CYC = `HCCR_CAL2_MS * `HCCR_CLK_KHZ,
  parameter int CAL3_CYC = `HCCR_CAL3_MS * `HCCR_CLK_KHZ,
  parameter int MCW = 16
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [2:0] mode_in,
  input wire logic [39:0] otp_src_in,
  input wire logic input_trigger_pin,
  input wire logic [7:0] analog_level_in,
  input wire logic [7:0] vdd_code_in,
  input wire logic driving_in,
  input wire logic cal_start_in,
  input wire logic [7:0] resonance_period_code,
  output logic cal_busy_out,
  output logic [7:0] amplitude_out,
  output logic amplitude_valid_out,
  output logic linear_actuator_fixed_freq,
  output logic comm_tick_out,
  output logic otp_wr_out,
  output logic [39:0] otp_data_out
);
  if (CAL0_CYC < 1 || CAL3_CYC < CAL2_CYC) begin : g_cal_chk
    $error("hccr_regs: bad calibration counts");
  end
  logic [1:0] ctrl3_q;
  logic [1:0] cal_sel_q;
  logic otp_prog_q, otp_stat_q;
  logic [7:0] vmon_q, rper_q;
  logic [2:0] pin_sync_q;
  logic pin_q;
  logic [31:0] cal_cnt_q;
  logic [4:0] otp_cnt_q;
  hccr_otp_e otp_st_q;
  logic [7:0] duty;
  logic wr4, launch, pwm_mode, ana_mode;

  function automatic logic [31:0] cal_len(input logic [1:0] sel);
    case (sel)
      2'h0: cal_len = 32'(CAL0_CYC);
      2'h1: cal_len = 32'(CAL1_CYC);
      2'h2: cal_len = 32'(CAL2_CYC);
      default: cal_len = 32'(CAL3_CYC);
    endcase
  endfunction

  assign wr4 = wr_in && addr_in == `HCCR_ADDR_CTRL4;
  assign launch = wr4 && wdata_in[`HCCR_C4_OTP_PROG];
  assign pwm_mode = mode_in == `HCCR_MODE_INPUT && !ctrl3_q[`HCCR_C3_ANALOG_SEL];
  assign ana_mode = mode_in == `HCCR_MODE_INPUT && ctrl3_q[`HCCR_C3_ANALOG_SEL];

  // Pin synchroniser, change taken when stages two and three agree
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_sync_q <= 3'h0;
      pin_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], input_trigger_pin};
      if (pin_sync_q[1] == pin_sync_q[2]) pin_q <= pin_sync_q[2];
    end
  end

  hccr_pwm_meter #(.CW(MCW)) u_meter (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pin_in(pin_q),
    .duty_out(duty),
    .comm_tick_out(comm_tick_out)
  );

  // Register writes
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl3_q <= 2'h0;
      cal_sel_q <= `HCCR_CAL_RESET;
      rper_q <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == `HCCR_ADDR_CTRL3)
        ctrl3_q <= wdata_in[`HCCR_C3_ANALOG_SEL:`HCCR_C3_FIXED_FREQ];
      if (wr4) cal_sel_q <= wdata_in[`HCCR_C4_CAL_HI:`HCCR_C4_CAL_LO];
      if (addr_in == `HCCR_ADDR_RPER) rper_q <= wdata_in;
    end else if (driving_in) begin
      rper_q <= resonance_period_code;
    end
  end

  assign linear_actuator_fixed_freq = ctrl3_q[`HCCR_C3_FIXED_FREQ];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      amplitude_out <= 8'h00;
      amplitude_valid_out <= 1'b0;
    end else begin
      amplitude_valid_out <= pwm_mode | ana_mode;
      if (pwm_mode) amplitude_out <= duty;
      else if (ana_mode) amplitude_out <= analog_level_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cal_cnt_q <= 32'h0;
      cal_busy_out <= 1'b0;
    end else if (cal_start_in && !cal_busy_out) begin
      cal_cnt_q <= cal_len(cal_sel_q);
      cal_busy_out <= 1'b1;
    end else if (cal_busy_out) begin
      cal_cnt_q <= cal_cnt_q - 32'h1;
      if (cal_cnt_q == 32'h1) cal_busy_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      otp_st_q <= HCCR_OTP_IDLE;
      otp_cnt_q <= 5'h0;
      otp_prog_q <= 1'b0;
      otp_stat_q <= 1'b0;
      otp_wr_out <= 1'b0;
      otp_data_out <= 40'h0;
    end else begin
      otp_wr_out <= 1'b0;
      case (otp_st_q)
        HCCR_OTP_IDLE: begin
          if (launch) begin
            otp_st_q <= HCCR_OTP_BUSY;
            otp_prog_q <= 1'b1;
            otp_data_out <= otp_src_in;
            otp_wr_out <= 1'b1;
            otp_cnt_q <= 5'(`HCCR_OTP_PROG_CYC);
          end
        end
        HCCR_OTP_BUSY: begin
          otp_cnt_q <= otp_cnt_q - 5'h1;
          if (otp_cnt_q == 5'h1) begin
            otp_st_q <= HCCR_OTP_DONE;
            otp_prog_q <= 1'b0;
            otp_stat_q <= 1'b1;
          end
        end
        HCCR_OTP_DONE: otp_st_q <= HCCR_OTP_DONE;
        default: otp_st_q <= HCCR_OTP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) vmon_q <= 8'h00;
    else if (wr_in && addr_in == `HCCR_ADDR_VMON) vmon_q <= wdata_in;
    else if (driving_in) vmon_q <= vdd_code_in;
  end

  // Read mux, reserved bits zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) rdata_out <= 8'h00;
    else if (rd_in) begin
      case (addr_in)
        `HCCR_ADDR_CTRL3: rdata_out <= {6'h00, ctrl3_q};
        `HCCR_ADDR_CTRL4: rdata_out <= {2'h0, cal_sel_q, 1'b0, otp_stat_q, 1'b0, otp_prog_q};
        `HCCR_ADDR_VMON: rdata_out <= vmon_q;
        `HCCR_ADDR_RPER: rdata_out <= rper_q;
        default: rdata_out <= 8'h00;
      endcase
    end
  end

  sequence launch_s;
    launch && otp_st_q == HCCR_OTP_IDLE;
  endsequence
  sequence done_s;
    otp_stat_q ##1 otp_stat_q;
  endsequence
  otp_launch_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    launch_s |=> otp_wr_out ##16 done_s) else $error("program sequence wrong");
  otp_once_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    otp_stat_q |-> !otp_wr_out) else $error("second program");
  otp_stat_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(otp_stat_q) |-> $past(otp_st_q) == HCCR_OTP_BUSY) else $error("status early");
  cal_reset_a: assert property (@(posedge mclk_in)
    $fell(rst_in) |-> cal_sel_q == `HCCR_CAL_RESET) else $error("cal reset");
  cal_len_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    cal_start_in && !cal_busy_out |=> cal_cnt_q == cal_len(cal_sel_q)) else $error("cal len");
  vmon_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !driving_in && !wr_in |=> $stable(vmon_q)) else $error("vmon moved");
  vmon_take_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    driving_in && !wr_in |=> vmon_q == $past(vdd_code_in)) else $error("vmon stale");
  amp_ana_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ana_mode |=> amplitude_out == $past(analog_level_in)) else $error("analog amp");
  amp_pwm_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    pwm_mode |=> amplitude_out == $past(duty)) else $error("pwm amp");
  rsv_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    rdata_out[7:6] == 2'h0 || $past(addr_in) != `HCCR_ADDR_CTRL4) else $error("reserved");
endmodule // hccr_regs
`default_nettype wire

// File: sim/hccr_host.sv
// Host model: register bus master and input pin pulse source
`timescale 1ns/1ps
`default_nettype none
module hccr_host (
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic pin_out
);
  int per = 0;
  int hi = 0;
  int ph = 0;
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    pin_out = 1'b0;
  end
  always @(posedge mclk_in) begin
    ph <= (ph + 1 >= per) ? 0 : ph + 1;
    pin_out <= #1 (per > 0) && (ph < hi);
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in) #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge mclk_in) #1;
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in) #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge mclk_in) #1;
    rd_out = 1'b0;
    d = rdata_in;
  endtask
endmodule // hccr_host
`default_nettype wire

// File: sim/haptic_control_config_regs_tb_top.sv
// Testbench for the haptic control configuration registers
`timescale 1ns/1ps
`default_nettype none
module haptic_control_config_regs_tb_top;
  import hccr_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} hccr_row_s;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] mode = 3'h0;
  logic [39:0] src = 40'h1a19181716;
  logic [7:0] an = 8'h77;
  logic [7:0] vdd = 8'h44;
  logic drv = 1'b0;
  logic cal_st = 1'b0;
  logic [7:0] pcode = 8'h3c;
  logic [7:0] rdata, addr, wdata, amp, r;
  logic wr, rd, pin, cal_busy, amp_v, ffreq, tick, otp_wr;
  logic [39:0] otp_data;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int n, t0;
  int cmin[4] = '{15, 25, 50, 100};
  int cmax[4] = '{35, 45, 70, 120};
  hccr_row_s rows[8] = '{'{8'h1d, 8'hff, 8'h03}, '{8'h1d, 8'h00, 8'h00},
    '{8'h1e, 8'hce, 8'h00}, '{8'h1e, 8'h10, 8'h10}, '{8'h1e, 8'h30, 8'h30},
    '{8'h21, 8'h5a, 8'h5a}, '{8'h22, 8'ha5, 8'ha5}, '{8'h40, 8'hff, 8'h00}};
  hccr_host host (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .pin_out(pin));
  hccr_regs #(.CAL0_CYC(15), .CAL1_CYC(25), .CAL2_CYC(50), .CAL3_CYC(100)) uut (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .mode_in(mode), .otp_src_in(src),
    .input_trigger_pin(pin), .analog_level_in(an), .vdd_code_in(vdd), .driving_in(drv),
    .cal_start_in(cal_st), .resonance_period_code(pcode), .cal_busy_out(cal_busy),
    .amplitude_out(amp), .amplitude_valid_out(amp_v), .linear_actuator_fixed_freq(ffreq),
    .comm_tick_out(tick), .otp_wr_out(otp_wr), .otp_data_out(otp_data));
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    cycles(5);
    rst_in = 1'b0;
    host.rd(8'h1e, r);
    chk("ctrl4_reset", 8'h20, r);
    for (int i = 0; i < 8; i++) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, r);
      chk("row_read", rows[i].e, r);
    end
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h1e, {2'b00, c[1:0], 4'h0});
      cal_st = 1'b1;
      cycles(1);
      cal_st = 1'b0;
      n = 0;
      while (cal_busy === 1'b1 && n < 200) begin
        cycles(1);
        n++;
      end
      chk("cal_len_ok", 1'b1, n >= cmin[c] && n <= cmax[c]);
    end
    mode = 3'h3;
    host.wr(8'h1d, 8'h02);
    cycles(10);
    chk("analog_amp", {1'b1, an}, {amp_v, amp});
    chk("fixed_off", 1'b0, ffreq);
    host.per = 16;
    host.hi = 8;
    host.wr(8'h1d, 8'h01);
    chk("fixed_on", 1'b1, ffreq);
    cycles(200);
    chk("pwm_amp", 1'b1, amp >= 8'h70 && amp <= 8'h90);
    n = 0;
    while (tick !== 1'b1 && n < 3000) begin
      cycles(1);
      n++;
    end
    t0 = cyc;
    cycles(1);
    n = 0;
    while (tick !== 1'b1 && n < 3000) begin
      cycles(1);
      n++;
    end
    chk("comm_period", 128 * 16, cyc - t0);
    host.per = 0;
    host.rd(8'h21, r);
    chk("vmon_idle", 8'h5a, r);
    drv = 1'b1;
    cycles(4);
    drv = 1'b0;
    host.rd(8'h21, r);
    chk("vmon_drive", vdd, r);
    host.rd(8'h22, r);
    chk("period_drive", pcode, r);
    host.wr(8'h1e, 8'h21);
    chk("otp_launch", {1'b1, src}, {otp_wr, otp_data});
    cycles(20);
    host.rd(8'h1e, r);
    chk("otp_status", 8'h24, r);
    src = 40'h0123456789;
    host.wr(8'h1e, 8'h21);
    n = 0;
    repeat (20) begin
      n += (otp_wr === 1'b1);
      cycles(1);
    end
    chk("otp_again", 41'h1a19181716, {n != 0, otp_data});
    host.rd(8'h1e, r);
    chk("otp_stat_kept", 8'h04, r & 8'h04);
    close_out();
  end
endmodule // haptic_control_config_regs_tb_top
`default_nettype wire
